// File: logic/phy_poll_and_style_config.v
// Design decision made here: the APB interface to the registers.
`timescale 1ns/1ps
`include "phy_style_consts.vh"


module phy_poll_and_style_config (
  input  wire        sys_clk_i,
  input  wire        sys_rst_i,
  input  wire        psel_i,
  input  wire        penable_i,
  input  wire        pwrite_i,
  input  wire [11:0] paddr_i,
  input  wire [31:0] pwdata_i,
  input  wire [3:0]  pstrb_i,
  output reg  [31:0] prdata_o,
  output reg         pready_o,
  output reg         pslverr_o,
  input  wire        port_scan_i,
  input  wire        auto_neg_en_i,
  input  wire        poll_en_i,
  input  wire        mgmt_done_i,
  output reg         mgmt_start_o,
  output reg         mgmt_speed_frame_o,
  output reg         mgmt_speed_fast_o,
  output reg         mdc_tick_o,
  input  wire        eeprom_start_i,
  input  wire        eeprom_fail_i,
  input  wire        eeprom_load_i,
  input  wire [7:0]  eeprom_style_i,
  output reg  [7:0]  descriptor_layout_select_o,
  output reg         wide_structure_flag_o,
  output reg         burst_desc_en_o,
  output reg         vlan_en_o,
  output reg         addr64_desc_o,
  output reg         style_reserved_o
);

  // ****************************************************************
  // states
  // ****************************************************************
  localparam ST_IDLE  = 3'b001;
  localparam ST_SPEED = 3'b010;
  localparam ST_POLL  = 3'b100;

  localparam [31:0] MDC_DIV_FULL = `MDC_DIV - 1;
  localparam [4:0]  MDC_DIV_M1   = MDC_DIV_FULL[4:0];

  reg        force_fast_r;
  reg  [2:0] poll_dwell_select_r;
  reg  [7:0] style_r;
  reg  [2:0] state_r;
  reg  [2:0] state_nxt;
  reg        speed_pend_r;
  reg        force_cond_q_r;
  reg  [4:0] mdc_cnt_r;
  reg  [31:0] rdata_nxt;
  reg        hit;

  wire       setup_ph = psel_i & ~penable_i;
  wire       wr_en    = psel_i & penable_i & pwrite_i & pready_o
                        & ~pslverr_o & pstrb_i[0];
  wire       force_cond;
  wire       poll_due;
  wire       start_speed;
  wire       start_poll;
  wire       mdc_tick = (mdc_cnt_r == MDC_DIV_M1);

  // ****************************************************************
  // apb slave: decode in setup, answer in first access cycle
  // ****************************************************************
  always @* begin
    hit       = 1'b1;
    rdata_nxt = 32'h0000_0000;
    case (paddr_i)
      `OFS_PHY_CTRL: begin
        rdata_nxt[`FORCE_FAST_BIT] = force_fast_r;
        rdata_nxt[`DWELL_MSB:`DWELL_LSB] = poll_dwell_select_r;
      end
      `OFS_PHY_SETUP: begin
        rdata_nxt[`FORCE_FAST_BIT] = force_fast_r;
      end
      `OFS_STYLE_CTRL: begin
        // upper bits read zero to keep software portable
        rdata_nxt[`STYLE_MSB:`STYLE_LSB] = style_r;
      end
      `OFS_POLL_STATUS: begin
        rdata_nxt[2:0] = state_r;
        rdata_nxt[3]   = speed_pend_r;
        rdata_nxt[4]   = force_cond;
      end
      default: begin
        hit = 1'b0;
      end
    endcase
  end

  always @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o  <= 32'h0000_0000;
    end else begin
      pready_o  <= setup_ph;
      pslverr_o <= setup_ph & ~hit;
      if (setup_ph && !pwrite_i && hit) begin
        prdata_o <= rdata_nxt;
      end else if (setup_ph) begin
        prdata_o <= 32'h0000_0000;
      end
    end
  end

  // ****************************************************************
  // phy control fields
  // ****************************************************************
  always @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      force_fast_r        <= `FORCE_FAST_RST;
      poll_dwell_select_r <= `DWELL_RST;
    end else if (wr_en) begin
      if (paddr_i == `OFS_PHY_CTRL) begin
        force_fast_r        <= pwdata_i[`FORCE_FAST_BIT];
        poll_dwell_select_r <= pwdata_i[`DWELL_MSB:`DWELL_LSB];
      end else if (paddr_i == `OFS_PHY_SETUP) begin
        force_fast_r        <= pwdata_i[`FORCE_FAST_BIT];
      end
    end
  end

  // ****************************************************************
  // style register
  // ****************************************************************
  // eeprom events beat a software write landing in the same cycle
  always @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      style_r <= `STYLE_RST;
    end else if (eeprom_start_i || eeprom_fail_i) begin
      style_r <= `STYLE_RST;
    end else if (eeprom_load_i) begin
      style_r <= eeprom_style_i;
    end else if (wr_en && paddr_i == `OFS_STYLE_CTRL) begin
      style_r <= pwdata_i[`STYLE_MSB:`STYLE_LSB];
    end
  end

  // only layout outputs follow the style; phy logic never reads it
  always @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      descriptor_layout_select_o <= `STYLE_RST;
      wide_structure_flag_o      <= 1'b0;
      burst_desc_en_o            <= 1'b0;
      vlan_en_o                  <= 1'b0;
      addr64_desc_o              <= 1'b0;
      style_reserved_o           <= 1'b0;
    end else begin
      descriptor_layout_select_o <= style_r;
      wide_structure_flag_o      <= (style_r != `STYLE_16BIT);
      burst_desc_en_o  <= (style_r == `STYLE_32BIT_BURST) ||
                          (style_r == `STYLE_VLAN) ||
                          (style_r == `STYLE_ADDR64);
      vlan_en_o        <= (style_r == `STYLE_VLAN);
      addr64_desc_o    <= (style_r == `STYLE_ADDR64);
      style_reserved_o <= (style_r != `STYLE_16BIT) &&
                          (style_r < `STYLE_32BIT ||
                           style_r > `STYLE_ADDR64);
    end
  end

  // ****************************************************************
  // management clock enable
  // ****************************************************************
  always @(posedge sys_clk_i) begin
    if (sys_rst_i || mdc_tick) begin
      mdc_cnt_r <= 5'h00;
    end else begin
      mdc_cnt_r <= mdc_cnt_r + 5'h01;
    end
  end

  always @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      mdc_tick_o <= 1'b0;
    end else begin
      mdc_tick_o <= mdc_tick;
    end
  end

  // ****************************************************************
  // forced speed request
  // ****************************************************************
  assign force_cond = force_fast_r & ~auto_neg_en_i & port_scan_i;

  // a rewrite of the bit while scanning re-arms the frame
  always @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      force_cond_q_r <= 1'b0;
      speed_pend_r   <= 1'b0;
    end else begin
      force_cond_q_r <= force_cond;
      if ((force_cond && !force_cond_q_r) ||
          (force_cond && wr_en && pwdata_i[`FORCE_FAST_BIT] &&
           (paddr_i == `OFS_PHY_CTRL || paddr_i == `OFS_PHY_SETUP))) begin
        speed_pend_r <= 1'b1;
      end else if (!port_scan_i || start_speed) begin
        speed_pend_r <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // frame sequencer: speed frame has priority over polling
  // ****************************************************************
  assign start_speed = (state_r == ST_IDLE) & speed_pend_r & port_scan_i;
  assign start_poll  = (state_r == ST_IDLE) & ~start_speed &
                       poll_en_i & poll_due;

  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (start_speed) begin
          state_nxt = ST_SPEED;
        end else if (start_poll) begin
          state_nxt = ST_POLL;
        end
      end
      ST_SPEED: begin
        if (mgmt_done_i) begin
          state_nxt = ST_IDLE;
        end
      end
      ST_POLL: begin
        if (mgmt_done_i) begin
          state_nxt = ST_IDLE;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  always @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      state_r            <= ST_IDLE;
      mgmt_start_o       <= 1'b0;
      mgmt_speed_frame_o <= 1'b0;
      mgmt_speed_fast_o  <= 1'b0;
    end else begin
      state_r      <= state_nxt;
      mgmt_start_o <= start_speed | start_poll;
      if (start_speed) begin
        mgmt_speed_frame_o <= 1'b1;
        mgmt_speed_fast_o  <= 1'b1;
      end else if (start_poll) begin
        mgmt_speed_frame_o <= 1'b0;
        mgmt_speed_fast_o  <= 1'b0;
      end
    end
  end

  // interval is measured start to start, so a slow frame eats dwell
  poll_dwell_timer #(
    .CW (11)
  ) u_dwell (
    .sys_clk_i (sys_clk_i),
    .sys_rst_i (sys_rst_i),
    .restart_i (start_poll),
    .tick_i    (mdc_tick),
    .code_i    (poll_dwell_select_r),
    .due_o     (poll_due)
  );

endmodule

// File: logic/phy_style_consts.vh
`ifndef PHY_STYLE_CONSTS_VH
`define PHY_STYLE_CONSTS_VH

// ****************************************************************
// register byte offsets
// ****************************************************************
`define OFS_PHY_CTRL        12'h068
`define OFS_STYLE_CTRL      12'h074
`define OFS_PHY_SETUP       12'h080
`define OFS_POLL_STATUS     12'h084

// ****************************************************************
// field positions
// ****************************************************************
`define FORCE_FAST_BIT      3
`define DWELL_MSB           2
`define DWELL_LSB           0
`define STYLE_MSB           7
`define STYLE_LSB           0

// ****************************************************************
// reset values
// ****************************************************************
`define FORCE_FAST_RST      1'b0
`define DWELL_RST           3'h0
`define STYLE_RST           8'h00

// ****************************************************************
// style codes
// ****************************************************************
`define STYLE_16BIT         8'h00
`define STYLE_32BIT         8'h02
`define STYLE_32BIT_BURST   8'h03
`define STYLE_VLAN          8'h04
`define STYLE_ADDR64        8'h05

// ****************************************************************
// dwell codes and timing
// ****************************************************************
`define DWELL_CONT          3'h0
`define DWELL_LAST          3'h5
`define DWELL_BASE_CYCLES   64
`define SYS_CLK_HZ          40000000
`define MDC_HZ              2500000
`define MDC_DIV             (`SYS_CLK_HZ / `MDC_HZ)

`endif

// File: logic/poll_dwell_timer.v
`timescale 1ns/1ps
`include "phy_style_consts.vh"

// ****************************************************************
// dwell timer: counts management clock ticks since last poll start
// ****************************************************************
module poll_dwell_timer #(
  parameter CW = 11
) (
  input  wire       sys_clk_i,
  input  wire       sys_rst_i,
  input  wire       restart_i,
  input  wire       tick_i,
  input  wire [2:0] code_i,
  output wire       due_o
);

  reg  [CW-1:0] cnt_r;
  localparam [31:0] BASE_FULL = `DWELL_BASE_CYCLES;

  reg  [CW-1:0] limit;
  wire [CW-1:0] base = BASE_FULL[CW-1:0];

  // reserved codes fall back to continuous polling
  always @* begin
    if (code_i == `DWELL_CONT || code_i > `DWELL_LAST) begin
      limit = {CW{1'b0}};
    end else begin
      limit = base << (code_i - 3'h1);
    end
  end

  // counter saturates so a long frame never wraps the interval
  always @(posedge sys_clk_i) begin
    if (sys_rst_i || restart_i) begin
      cnt_r <= {CW{1'b0}};
    end else if (tick_i && cnt_r != {CW{1'b1}}) begin
      cnt_r <= cnt_r + {{(CW-1){1'b0}}, 1'b1};
    end
  end

  assign due_o = (limit == {CW{1'b0}}) || (cnt_r >= limit);

endmodule

// File: test/phy_cfg_monitor.sv
`timescale 1ns/1ps
// ********************
// port checker
// ********************
module phy_cfg_monitor (
  input wire        sys_clk_i,
  input wire        sys_rst_i,
  input wire        psel_i,
  input wire        penable_i,
  input wire        pready_o,
  input wire        pslverr_o,
  input wire [31:0] prdata_o,
  input wire        mgmt_start_o,
  input wire        mgmt_speed_frame_o,
  input wire        mgmt_speed_fast_o,
  input wire        mdc_tick_o,
  input wire        eeprom_start_i,
  input wire        eeprom_fail_i,
  input wire        eeprom_load_i,
  input wire [7:0]  eeprom_style_i,
  input wire [7:0]  descriptor_layout_select_o,
  input wire        wide_structure_flag_o,
  input wire        burst_desc_en_o,
  input wire        vlan_en_o,
  input wire        addr64_desc_o,
  input wire        style_reserved_o
);
  wire [7:0] sel = descriptor_layout_select_o;
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (sys_rst_i);
  sequence setup_s; psel_i && !penable_i; endsequence
  sequence done_s; psel_i && penable_i && pready_o; endsequence
  ready_first_a: assert property (setup_s |=> pready_o)
    else $error("no ready after setup");
  ready_pulse_a: assert property (done_s |=> !pready_o)
    else $error("ready held");
  err_data_a: assert property (
    pslverr_o |-> pready_o && prdata_o == 32'h0)
    else $error("bad error answer");
  wide_flag_a: assert property (
    wide_structure_flag_o == (sel != 8'h00))
    else $error("wide flag wrong");
  burst_flag_a: assert property (
    burst_desc_en_o == (sel inside {8'h03, 8'h04, 8'h05}))
    else $error("burst flag wrong");
  vlan_addr_a: assert property (
    {vlan_en_o, addr64_desc_o} == {sel == 8'h04, sel == 8'h05})
    else $error("vlan or addr64 flag wrong");
  resv_flag_a: assert property (
    style_reserved_o == (sel == 8'h01 || sel > 8'h05))
    else $error("reserved flag wrong");
  eeprom_clear_a: assert property (
    eeprom_start_i || eeprom_fail_i |-> ##2 sel == 8'h00)
    else $error("style not cleared");
  eeprom_load_a: assert property (
    eeprom_load_i && !eeprom_start_i && !eeprom_fail_i
    |-> ##2 sel == $past(eeprom_style_i, 2))
    else $error("style not loaded");
  tick_gap_a: assert property (mdc_tick_o |=> !mdc_tick_o [*8])
    else $error("tick too soon");
  tick_period_a: assert property (mdc_tick_o |-> ##16 mdc_tick_o)
    else $error("tick period wrong");
  start_pulse_a: assert property (mgmt_start_o |=> !mgmt_start_o)
    else $error("start held");
  speed_fast_a: assert property (
    mgmt_start_o && mgmt_speed_frame_o |-> mgmt_speed_fast_o)
    else $error("speed frame not fast");
endmodule
bind phy_poll_and_style_config phy_cfg_monitor mon (
  .sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .psel_i(psel_i),
  .penable_i(penable_i), .pready_o(pready_o), .pslverr_o(pslverr_o),
  .prdata_o(prdata_o), .mgmt_start_o(mgmt_start_o),
  .mgmt_speed_frame_o(mgmt_speed_frame_o),
  .mgmt_speed_fast_o(mgmt_speed_fast_o), .mdc_tick_o(mdc_tick_o),
  .eeprom_start_i(eeprom_start_i), .eeprom_fail_i(eeprom_fail_i),
  .eeprom_load_i(eeprom_load_i), .eeprom_style_i(eeprom_style_i),
  .descriptor_layout_select_o(descriptor_layout_select_o),
  .wide_structure_flag_o(wide_structure_flag_o),
  .burst_desc_en_o(burst_desc_en_o), .vlan_en_o(vlan_en_o),
  .addr64_desc_o(addr64_desc_o), .style_reserved_o(style_reserved_o));

// File: test/phy_mgmt_model.sv
`timescale 1ns/1ps
// ********************
// phy management side
// ********************
module phy_mgmt_model (
  input  wire       sys_clk_i,
  input  wire       sys_rst_i,
  input  wire       start_i,
  input  wire [7:0] lat_i,
  output reg        done_o
);
  reg [7:0] cnt_r;
  reg       busy_r;
  // lat_i stands for frame length, so a slow phy is one setting away
  always @(posedge sys_clk_i) begin
    done_o <= 1'b0;
    if (sys_rst_i) begin
      busy_r <= 1'b0;
      cnt_r  <= 8'h00;
    end else if (start_i) begin
      busy_r <= 1'b1;
      cnt_r  <= lat_i;
    end else if (busy_r) begin
      cnt_r <= cnt_r - 8'h01;
      if (cnt_r == 8'h00) begin
        busy_r <= 1'b0;
        done_o <= 1'b1;
      end
    end
  end
endmodule

// File: test/tb_phy_poll_and_style_config.sv
`timescale 1ns/1ps
`include "phy_style_consts.vh"
// ********************
// bench
// ********************
module tb_phy_poll_and_style_config;
  logic        clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0;
  logic        pwr = 1'b0, scan = 1'b0, aneg = 1'b0, poll = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [3:0]  pstrb = 4'hf;
  logic [2:0]  ee = 3'h0;
  logic [7:0]  sty = 8'h00, lat = 8'h05, sel;
  logic        pready, perr, er, kind, done, start, sfr, sfast;
  logic        wide, burst, vlan, a64, resv;
  wire  [4:0]  flags = {wide, burst, vlan, a64, resv};
  int          n_errors = 0, n_checks = 0, cyc = 0, i, t, n;
  logic [12:0] rows [0:7] = '{13'h0000, 13'h0031, 13'h0050, 13'h0078,
                              13'h009c, 13'h00ba, 13'h00d1, 13'h1ff1};
  logic [2:0]  dw [0:6] = '{3'h0, 3'h7, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5};
  phy_poll_and_style_config uut (
    .sys_clk_i(clk), .sys_rst_i(rst), .psel_i(psel), .penable_i(pen),
    .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(pstrb),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(perr),
    .port_scan_i(scan), .auto_neg_en_i(aneg), .poll_en_i(poll),
    .mgmt_done_i(done), .mgmt_start_o(start), .mgmt_speed_frame_o(sfr),
    .mgmt_speed_fast_o(sfast), .mdc_tick_o(), .eeprom_start_i(ee[2]),
    .eeprom_fail_i(ee[1]), .eeprom_load_i(ee[0]), .eeprom_style_i(sty),
    .descriptor_layout_select_o(sel), .wide_structure_flag_o(wide),
    .burst_desc_en_o(burst), .vlan_en_o(vlan), .addr64_desc_o(a64),
    .style_reserved_o(resv));
  phy_mgmt_model phy (.sys_clk_i(clk), .sys_rst_i(rst), .start_i(start),
                      .lat_i(lat), .done_o(done));
  initial forever #12.5 clk = ~clk;
  task print_verdict;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic chkb(input logic c);
    chk({31'h0, c}, 32'h1);
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int k;
    @(posedge clk);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    k = 0;
    @(posedge clk);
    while (pready !== 1'b1 && k < 20) begin
      @(posedge clk);
      k++;
    end
    if (k >= 20) n_errors++;
    rd = prdata;
    er = perr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask
  task automatic ee_pulse(input logic [2:0] v);
    @(posedge clk);
    ee <= v;
    @(posedge clk);
    ee <= 3'h0;
  endtask
  // the first edge only arms the wait, so spacing is w plus one
  task automatic wstart(input int lim, output int w);
    w = 0;
    @(posedge clk);
    while (start !== 1'b1 && w < lim) begin
      @(posedge clk);
      w++;
    end
    kind = sfr;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      n_errors++;
      print_verdict();
    end
  end
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    rdchk(`OFS_STYLE_CTRL, 32'h0);
    apb(1'b0, 12'h100, 32'h0);
    chkb(er === 1'b1 && rd === 32'h0);
    for (i = 0; i < 8; i++) begin
      apb(1'b1, `OFS_STYLE_CTRL, {24'h0, rows[i][12:5]});
      rdchk(`OFS_STYLE_CTRL, {24'h0, rows[i][12:5]});
      chk({27'h0, flags}, {27'h0, rows[i][4:0]});
    end
    pstrb <= 4'h0;
    apb(1'b1, `OFS_STYLE_CTRL, 32'h3);
    pstrb <= 4'hf;
    rdchk(`OFS_STYLE_CTRL, 32'hff);
    sty <= 8'h04;
    ee_pulse(3'b001);
    rdchk(`OFS_STYLE_CTRL, 32'h4);
    ee_pulse(3'b101);
    rdchk(`OFS_STYLE_CTRL, 32'h0);
    apb(1'b1, `OFS_STYLE_CTRL, 32'h3);
    ee_pulse(3'b010);
    rdchk(`OFS_STYLE_CTRL, 32'h0);
    apb(1'b1, `OFS_STYLE_CTRL, 32'h5);
    apb(1'b1, `OFS_PHY_CTRL, 32'hd);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rdchk(`OFS_STYLE_CTRL, 32'h0);
    rdchk(`OFS_PHY_CTRL, 32'h0);
    apb(1'b1, `OFS_PHY_CTRL, 32'h8);
    apb(1'b0, `OFS_PHY_SETUP, 32'h0);
    chk(rd & 32'h8, 32'h8);
    apb(1'b1, `OFS_PHY_SETUP, 32'h0);
    apb(1'b0, `OFS_PHY_CTRL, 32'h0);
    chk(rd & 32'h8, 32'h0);
    apb(1'b1, `OFS_PHY_CTRL, 32'h8);
    wstart(100, t);
    chkb(t == 100);
    scan <= 1'b1;
    wstart(50, t);
    chkb(t < 50 && kind === 1'b1 && sfast === 1'b1);
    apb(1'b1, `OFS_PHY_CTRL, 32'h0);
    aneg <= 1'b1;
    apb(1'b1, `OFS_PHY_CTRL, 32'h8);
    wstart(100, t);
    chkb(t == 100);
    scan <= 1'b0;
    poll <= 1'b1;
    for (i = 0; i < 7; i++) begin
      apb(1'b1, `OFS_PHY_CTRL, {29'h0, dw[i]});
      wstart(20000, t);
      wstart(20000, t);
      n = (dw[i] inside {[1:5]}) ? 64 << (dw[i] - 1) : 0;
      chkb(t >= n*16-17 && t < n*16+20 && kind === 1'b0);
    end
    apb(1'b1, `OFS_PHY_CTRL, 32'h0);
    lat <= 8'd60;
    wstart(20000, t);
    wstart(20000, t);
    chkb(t >= 60 && t < 80);
    print_verdict();
  end
endmodule
